// ### inc/irq_mask_pkg.sv
// Constants and types shared by the peripheral interrupt-enable mask block
package irq_mask_pkg;

  // ----------------------------------------------------------------------
  // Register map: offsets are word indexes, byte address is index * 4
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [9:0] MASK_A_INDEX = 10'h0e6;
  localparam logic [9:0] MASK_B_INDEX = 10'h0e7;
  localparam logic [9:0] REQ_STATUS_INDEX = 10'h0e8;
  localparam logic [ADDR_W-1:0] MASK_A_ADDR = {MASK_A_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] MASK_B_ADDR = {MASK_B_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] REQ_STATUS_ADDR = {REQ_STATUS_INDEX, 2'h0};

  // ----------------------------------------------------------------------
  // Field positions, writable masks and reset values
  // ----------------------------------------------------------------------
  localparam int MASK_A_SPI_BIT = 0;
  localparam int MASK_A_TWOWIRE_BIT = 1;
  localparam int MASK_A_ADC0_WIN_BIT = 2;
  localparam int MASK_B_TIMER3_BIT = 0;
  localparam int MASK_B_ADC0_DONE_BIT = 1;
  localparam int MASK_B_TIMER4_BIT = 2;
  localparam int MASK_B_ADC2_WIN_BIT = 3;
  localparam int MASK_B_ADC2_DONE_BIT = 4;
  localparam int MASK_B_UNUSED_LO_BIT = 5;
  localparam int MASK_B_SERIAL2_BIT = 6;
  localparam int MASK_B_UNUSED_HI_BIT = 7;
  localparam logic [7:0] MASK_A_WRITABLE = 8'h07;
  localparam logic [7:0] MASK_B_WRITABLE = 8'h5f;
  localparam logic [7:0] MASK_A_RESET = 8'h00;
  localparam logic [7:0] MASK_B_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Request source order on the request and gated vectors
  // ----------------------------------------------------------------------
  localparam int SRC_COUNT = 9;
  localparam int SRC_SPI = 0;
  localparam int SRC_TWOWIRE = 1;
  localparam int SRC_ADC0_WIN = 2;
  localparam int SRC_TIMER3 = 3;
  localparam int SRC_ADC0_DONE = 4;
  localparam int SRC_TIMER4 = 5;
  localparam int SRC_ADC2_WIN = 6;
  localparam int SRC_ADC2_DONE = 7;
  localparam int SRC_SERIAL2 = 8;

  // ----------------------------------------------------------------------
  // Bus answers and register selection
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {SEL_NONE, SEL_MASK_A, SEL_MASK_B, SEL_STATUS} reg_sel_t;

endpackage

// ### inc/irq_gate_if.sv
// Carrier between the mask controller and the request gate
`timescale 1ns/100ps
interface irq_gate_if #(parameter int N = 9);
  logic [N-1:0] req;
  logic [N-1:0] en;
  logic [N-1:0] gated;
  logic [N-1:0] seen;

  modport ctrl (output req, output en, input gated, input seen);
  modport gate (input req, input en, output gated, output seen);
endinterface

// ### logic/irq_gate.sv
// Registered enable gate between peripheral requests and the core
`timescale 1ns/100ps
module irq_gate
  import irq_mask_pkg::*;
#(
  parameter int N = SRC_COUNT
) (
  input wire logic clk,
  input wire logic rstN,
  irq_gate_if.gate g
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [N-1:0] gated;
    logic [N-1:0] seen;
  } gate_state_t;

  gate_state_t s;
  gate_state_t n;

  // Per-source gate; registering keeps the core input glitch free
  always_comb begin
    n = s;
    for (int i = 0; i < N; i++) begin
      n.gated[i] = g.req[i] & g.en[i];
      n.seen[i] = g.req[i];
    end
  end

  // Cleared at reset so no request leaks before software enables it
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign g.gated = s.gated;
  assign g.seen = s.seen;

endmodule

// ### logic/irq_mask_ctrl.sv
// Peripheral interrupt-enable masks with an AXI4-Lite register slave
//
// Behaviour
// R1: First mask register bit 2 gates the ADC0 window-compare request; 1 passes.
// R2: First mask register bit 1 gates the two-wire bus request; 1 passes.
// R3: First mask register bit 0 gates the serial peripheral request; 1 passes.
// R4: Second mask register bit 6 gates the second serial port request; 1 passes.
// R5: Second mask register bit 4 gates the ADC2 conversion-done request; 1 passes.
// R6: Second mask register decodes at index 0xE7, independent of any page select.
// R7: Second mask register bits 7 and 5 are unused and always read zero.
// R8: Second mask register bit 3 gates the ADC2 window-compare request; 1 passes.
// R9: Second mask register bit 2 gates the timer four request; 1 passes.
// R10: Second mask register bit 1 gates the ADC0 conversion-done request; 1 passes.
// R11: Second mask register bit 0 gates the timer three request; 1 passes.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
module irq_mask_ctrl
  import irq_mask_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [SRC_COUNT-1:0] irqReq,
  output logic [SRC_COUNT-1:0] irqOut
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic [1:0] rstPipe_reg;
  logic rstSyncN;

  // Asserts at once, releases two edges later so all flops leave reset together
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_reg <= 2'h0;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe_reg[1];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [7:0] wByte;
    logic wLane0;
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [7:0] maskA;
    logic [7:0] maskB;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t n;

  irq_gate_if #(.N(SRC_COUNT)) gateBus ();

  // ----------------------------------------------------------------------
  // Address decode, shared by the read and write paths
  // ----------------------------------------------------------------------
  // Low two address bits are ignored: every register is one aligned word
  function automatic reg_sel_t decodeSel(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr[ADDR_W-1:2] == MASK_A_INDEX) begin
      sel = SEL_MASK_A;
    end else if (addr[ADDR_W-1:2] == MASK_B_INDEX) begin
      sel = SEL_MASK_B; // R6
    end else if (addr[ADDR_W-1:2] == REQ_STATUS_INDEX) begin
      sel = SEL_STATUS;
    end
    return sel;
  endfunction

  // ----------------------------------------------------------------------
  // Bus slave and mask registers
  // ----------------------------------------------------------------------
  // Address and data are caught in either order; the write lands once both are held
  always_comb begin
    reg_sel_t wrSel;
    reg_sel_t rdSel;
    wrSel = decodeSel(s.awAddr);
    rdSel = decodeSel(araddr);
    n = s;
    if (s.awReady && awvalid) begin
      n.awHeld = 1'b1;
      n.awAddr = awaddr;
    end
    if (s.wReady && wvalid) begin
      n.wHeld = 1'b1;
      n.wByte = wdata[7:0];
      n.wLane0 = wstrb[0];
    end
    if (s.bValid && bready) begin
      n.bValid = 1'b0;
    end
    if (s.awHeld && s.wHeld && !s.bValid) begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bValid = 1'b1;
      n.bResp = RESP_OKAY;
      unique case (wrSel)
        SEL_MASK_A: begin
          // Upper lanes carry nothing; only lane 0 can change a mask
          if (s.wLane0) begin
            n.maskA = s.wByte & MASK_A_WRITABLE; // R1 R2 R3
          end
        end
        SEL_MASK_B: begin
          if (s.wLane0) begin
            n.maskB = s.wByte & MASK_B_WRITABLE; // R6 R7
          end
        end
        SEL_STATUS: begin
          n.bResp = RESP_OKAY; // Read-only, write dropped
        end
        SEL_NONE: begin
          n.bResp = RESP_SLVERR;
        end
      endcase
    end
    // No new address or data while an answer is still waiting
    n.awReady = !n.awHeld && !n.bValid;
    n.wReady = !n.wHeld && !n.bValid;

    if (s.rValid && rready) begin
      n.rValid = 1'b0;
    end
    if (s.arReady && arvalid) begin
      n.rValid = 1'b1;
      n.rResp = RESP_OKAY;
      n.rData = 32'h0000_0000;
      unique case (rdSel)
        SEL_MASK_A: begin
          n.rData[7:0] = s.maskA;
        end
        SEL_MASK_B: begin
          n.rData[7:0] = s.maskB & MASK_B_WRITABLE; // R7
        end
        SEL_STATUS: begin
          n.rData[SRC_COUNT-1:0] = gateBus.seen;
        end
        SEL_NONE: begin
          n.rResp = RESP_SLVERR;
        end
      endcase
    end
    n.arReady = !n.rValid;
  end

  // Register the whole state; masks start closed
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      s <= '0;
      s.maskA <= MASK_A_RESET;
      s.maskB <= MASK_B_RESET;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Enable vector toward the gate
  // ----------------------------------------------------------------------
  // Requests come from logic on this clock, so they are not synchronised
  assign gateBus.req = irqReq;
  assign gateBus.en[SRC_SPI] = s.maskA[MASK_A_SPI_BIT]; // R3
  assign gateBus.en[SRC_TWOWIRE] = s.maskA[MASK_A_TWOWIRE_BIT]; // R2
  assign gateBus.en[SRC_ADC0_WIN] = s.maskA[MASK_A_ADC0_WIN_BIT]; // R1
  assign gateBus.en[SRC_TIMER3] = s.maskB[MASK_B_TIMER3_BIT]; // R11
  assign gateBus.en[SRC_ADC0_DONE] = s.maskB[MASK_B_ADC0_DONE_BIT]; // R10
  assign gateBus.en[SRC_TIMER4] = s.maskB[MASK_B_TIMER4_BIT]; // R9
  assign gateBus.en[SRC_ADC2_WIN] = s.maskB[MASK_B_ADC2_WIN_BIT]; // R8
  assign gateBus.en[SRC_ADC2_DONE] = s.maskB[MASK_B_ADC2_DONE_BIT]; // R5
  assign gateBus.en[SRC_SERIAL2] = s.maskB[MASK_B_SERIAL2_BIT]; // R4

  irq_gate #(.N(SRC_COUNT)) gateInst (
    .clk(clk),
    .rstN(rstSyncN),
    .g(gateBus.gate)
  );

  // Outputs come straight from flops here or inside the gate
  assign awready = s.awReady;
  assign wready = s.wReady;
  assign bvalid = s.bValid;
  assign bresp = s.bResp;
  assign arready = s.arReady;
  assign rvalid = s.rValid;
  assign rdata = s.rData;
  assign rresp = s.rResp;
  assign irqOut = gateBus.gated;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstSyncN);

  logic wrFire;
  assign wrFire = s.awHeld && s.wHeld && !s.bValid && s.wLane0;

  chk_adc0win_gate: assert property ( // R1
    irqOut[SRC_ADC0_WIN] == ($past(irqReq[SRC_ADC0_WIN]) && $past(s.maskA[MASK_A_ADC0_WIN_BIT])))
    else $error("ADC0 window request not gated by its enable");

  chk_twowire_block: assert property ( // R2
    !s.maskA[MASK_A_TWOWIRE_BIT] |=> !irqOut[SRC_TWOWIRE])
    else $error("Two-wire request passed while disabled");

  chk_spi_pass: assert property ( // R3
    (s.maskA[MASK_A_SPI_BIT] && irqReq[SRC_SPI]) |=> irqOut[SRC_SPI])
    else $error("Serial peripheral request lost while enabled");

  chk_serial2_gate: assert property ( // R4
    irqOut[SRC_SERIAL2] == ($past(irqReq[SRC_SERIAL2]) && $past(s.maskB[MASK_B_SERIAL2_BIT])))
    else $error("Second serial port request not gated by its enable");

  chk_adc2done_gate: assert property ( // R5
    (irqReq[SRC_ADC2_DONE] ##0 s.maskB[MASK_B_ADC2_DONE_BIT]) |=> irqOut[SRC_ADC2_DONE])
    else $error("ADC2 conversion-done request lost while enabled");

  chk_maskb_write: assert property ( // R6
    (wrFire && decodeSel(s.awAddr) == SEL_MASK_B) |=> (s.maskB == ($past(s.wByte) & MASK_B_WRITABLE)) && bvalid)
    else $error("Write at the second mask address did not land");

  chk_unused_zero: assert property ( // R7
    (arvalid && arready && decodeSel(araddr) == SEL_MASK_B) |=>
      rvalid && rdata[MASK_B_UNUSED_HI_BIT] == 1'b0 && rdata[MASK_B_UNUSED_LO_BIT] == 1'b0 &&
      rdata[4:0] == $past(s.maskB[4:0]))
    else $error("Second mask read showed unused bits or stale value");

  chk_adc2win_block: assert property ( // R8
    !s.maskB[MASK_B_ADC2_WIN_BIT] |=> !irqOut[SRC_ADC2_WIN])
    else $error("ADC2 window request passed while disabled");

  chk_timer4_gate: assert property ( // R9
    irqOut[SRC_TIMER4] == ($past(irqReq[SRC_TIMER4]) && $past(s.maskB[MASK_B_TIMER4_BIT])))
    else $error("Timer four request not gated by its enable");

  chk_adc0done_gate: assert property ( // R10
    $rose(irqOut[SRC_ADC0_DONE]) |-> $past(s.maskB[MASK_B_ADC0_DONE_BIT]) && $past(irqReq[SRC_ADC0_DONE]))
    else $error("ADC0 conversion-done output rose without enabled request");

  chk_timer3_gate: assert property ( // R11
    (s.maskB[MASK_B_TIMER3_BIT] && irqReq[SRC_TIMER3]) |=> irqOut[SRC_TIMER3])
    else $error("Timer three request lost while enabled");

  chk_write_answer: assert property (
    (awvalid && awready) ##0 (wvalid && wready) |-> ##[1:2] bvalid)
    else $error("Write answer missing two cycles after address and data");

  chk_maska_write: assert property ( // R1 R2 R3
    (wrFire && decodeSel(s.awAddr) == SEL_MASK_A) |=> s.maskA == ($past(s.wByte) & MASK_A_WRITABLE))
    else $error("Write at the first mask address did not land");

  // A pending answer must block new address and data, or a write could be lost
  chk_write_busy: assert property (
    bvalid |-> !awready && !wready)
    else $error("Write channels ready while an answer is pending");

  chk_read_busy: assert property (
    rvalid |-> !arready)
    else $error("Read address ready while read data is pending");

  chk_status_read: assert property (
    (arvalid && arready && decodeSel(araddr) == SEL_STATUS) |=>
      rdata[SRC_COUNT-1:0] == $past(irqReq, 2) && rdata[31:SRC_COUNT] == '0)
    else $error("Status read did not show the registered requests");

  chk_unmapped_read: assert property (
    (arvalid && arready && decodeSel(araddr) == SEL_NONE) |=> rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("Unmapped read not answered with error and zero data");

  cov_enable_then_fire: cover property (
    (wrFire && decodeSel(s.awAddr) == SEL_MASK_B) ##[1:20] irqOut[SRC_TIMER3]);
  cov_blocked_request: cover property (irqReq[SRC_SPI] && !s.maskA[MASK_A_SPI_BIT]);
  cov_unmapped_read: cover property (rvalid && rresp == RESP_SLVERR);
  cov_data_first: cover property ((wvalid && wready && !awvalid) ##1 (awvalid && awready));
  cov_status_read: cover property (arvalid && arready && decodeSel(araddr) == SEL_STATUS);

endmodule

// ### testbench/irq_source_model.sv
// Peripheral request sources that drive the mask block's request inputs
`timescale 1ns/100ps
module irq_source_model
  import irq_mask_pkg::*;
(
  input wire logic clk,
  input wire logic [SRC_COUNT-1:0] pattern,
  output logic [SRC_COUNT-1:0] irqReq
);
  // Sources launch their levels from a flop, like real peripherals
  always_ff @(posedge clk) begin
    irqReq <= pattern;
  end
endmodule

// ### testbench/ext_interrupt_enable_masks_bench.sv
// Self-checking bench for the peripheral interrupt-enable mask block
`timescale 1ns/100ps
module ext_interrupt_enable_masks_bench;
  import irq_mask_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [SRC_COUNT-1:0] pattern = '0;
  logic [SRC_COUNT-1:0] irqReq;
  logic [SRC_COUNT-1:0] irqOut;
  logic [31:0] rd;
  logic [1:0] rsp;
  int mismatches = 0;
  int n_compared = 0;
  // One-hot enable per source: low byte first mask, high byte second mask
  logic [15:0] enTab [SRC_COUNT] = '{16'h0001, 16'h0002, 16'h0004, 16'h0100, 16'h0200,
                                     16'h0400, 16'h0800, 16'h1000, 16'h4000};

  always #2 clk = ~clk;

  irq_mask_ctrl dut (.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .irqReq(irqReq), .irqOut(irqOut));

  irq_source_model src (.clk(clk), .pattern(pattern), .irqReq(irqReq));

  // ----------------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Address and data offered together; each dropped once its ready is seen
  // No answer time is assumed; only the watchdog ends a wait that never closes
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [1:0] r,
    input logic [3:0] strb = 4'hf);
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= strb;
    wvalid <= 1'b1;
    bready <= 1'b1;
    r = 2'h3;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        r = bresp;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    d = 'x;
    r = 2'h3;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        break;
      end
    end
  endtask

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog: the tests need a few hundred cycles at most
  initial begin
    #200000;
    mismatches++;
    close_out();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values, fixed decode of the second mask, gates closed
    axi_rd(MASK_B_ADDR, rd, rsp);
    chk("maskB reset", 32'h0, rd);
    chk("maskB rresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    axi_rd(MASK_A_ADDR, rd, rsp);
    chk("maskA reset", 32'h0, rd);
    pattern <= 9'h1ff;
    repeat (3) @(posedge clk);
    chk("closed after reset", 32'h0, {23'h0, irqOut});
    // Status shows the raw requests; a write to it is dropped with OKAY
    axi_wr(REQ_STATUS_ADDR, 8'h00, rsp);
    chk("status bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    axi_rd(REQ_STATUS_ADDR, rd, rsp);
    chk("status readback", 32'h1ff, rd);
    // Unused bits refuse ones
    axi_wr(MASK_B_ADDR, 8'hff, rsp);
    chk("maskB bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    axi_rd(MASK_B_ADDR, rd, rsp);
    chk("maskB unused bits", 32'h5f, rd);
    axi_wr(MASK_A_ADDR, 8'hff, rsp);
    axi_rd(MASK_A_ADDR, rd, rsp);
    chk("maskA readback", 32'h07, rd);
    // All enabled: every raised request passes
    repeat (3) @(posedge clk);
    chk("all enabled", 32'h1ff, {23'h0, irqOut});
    // Each enable alone: only its own source passes, and only while requested
    for (int i = 0; i < SRC_COUNT; i++) begin
      axi_wr(MASK_A_ADDR, enTab[i][7:0], rsp);
      axi_wr(MASK_B_ADDR, enTab[i][15:8], rsp);
      pattern <= 9'h1ff;
      repeat (3) @(posedge clk);
      chk($sformatf("one enabled %0d", i), 32'h1 << i, {23'h0, irqOut});
      pattern <= ~(9'h1 << i);
      repeat (3) @(posedge clk);
      chk($sformatf("request low %0d", i), 32'h0, {23'h0, irqOut});
    end
    // Clearing the masks blocks everything
    pattern <= 9'h1ff;
    axi_wr(MASK_B_ADDR, 8'h00, rsp);
    repeat (3) @(posedge clk);
    chk("all blocked", 32'h0, {23'h0, irqOut});
    // Lane 0 strobe low: answered OKAY, mask left alone
    axi_wr(MASK_B_ADDR, 8'h5f, rsp, 4'he);
    chk("lane off bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    // Unmapped place: error answers, no side effect on the mask
    axi_wr(12'h3fc, 8'h5f, rsp);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    axi_rd(12'h3fc, rd, rsp);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk("unmapped rdata", 32'h0, rd);
    axi_rd(MASK_B_ADDR, rd, rsp);
    chk("maskB after unmapped", 32'h0, rd);
    // A reset in mid-run closes every mask again
    axi_wr(MASK_A_ADDR, 8'h07, rsp);
    axi_wr(MASK_B_ADDR, 8'h5f, rsp);
    repeat (3) @(posedge clk);
    chk("open before second reset", 32'h1ff, {23'h0, irqOut});
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("closed after second reset", 32'h0, {23'h0, irqOut});
    axi_rd(MASK_A_ADDR, rd, rsp);
    chk("maskA after second reset", 32'h0, rd);
    axi_rd(MASK_B_ADDR, rd, rsp);
    chk("maskB after second reset", 32'h0, rd);
    close_out();
  end
endmodule
